// ### pkg/fuel_pkg.sv
package fuel_pkg;

	// register byte offsets
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_INTERVAL = 8'h04;
	localparam logic [7:0] REG_CAL      = 8'h08;
	localparam logic [7:0] REG_COMP     = 8'h0C;
	localparam logic [7:0] REG_POLY_AB  = 8'h10;
	localparam logic [7:0] REG_POLY_CD  = 8'h14;
	localparam logic [7:0] REG_TANK     = 8'h18;
	localparam logic [7:0] REG_OUT      = 8'h1C;
	localparam logic [7:0] REG_FREQ     = 8'h20;
	localparam logic [7:0] REG_CALC     = 8'h24;
	localparam logic [7:0] REG_STAT     = 8'h28;
	localparam logic [7:0] REG_TBL      = 8'h40;

	// control field positions
	localparam int CTRL_EXP    = 0;
	localparam int CTRL_COMP   = 1;
	localparam int CTRL_POLY   = 2;
	localparam int CTRL_LEGACY = 3;
	localparam int CTRL_BAUD   = 4;
	localparam int CTRL_BOX    = 8;

	// serial rate codes
	localparam logic [2:0] BAUD_9600   = 3'h0;
	localparam logic [2:0] BAUD_14400  = 3'h1;
	localparam logic [2:0] BAUD_19200  = 3'h2;
	localparam logic [2:0] BAUD_38400  = 3'h3;
	localparam logic [2:0] BAUD_57600  = 3'h4;
	localparam logic [2:0] BAUD_115200 = 3'h5;

	// reset values and interval minimum
	localparam logic [1:0]  BOX_LOG_RST  = 2'h2;
	localparam logic [7:0]  INTERVAL_RST = 8'h0A;
	localparam logic [7:0]  INTERVAL_MIN = 8'h05;
	localparam logic [15:0] UNITY_Q8     = 16'h0100;
	localparam logic [15:0] CEILING_RST  = 16'h03FF;

	// 3.5 in q8, smoothing coefficient numerator
	localparam logic [15:0] ALPHA_Q8 = 16'h0380;
	localparam int LVL_SCALE = 1000;
	localparam int TBL_N     = 8;

	// error indices and code bases
	localparam logic [2:0] ERRI_NONE      = 3'h0;
	localparam logic [2:0] ERRI_UNCAL_ALL = 3'h1;
	localparam logic [2:0] ERRI_UNCAL_TOP = 3'h2;
	localparam logic [2:0] ERRI_ZERO_FREQ = 3'h3;
	localparam logic [2:0] ERRI_SAME_CAL  = 3'h4;
	localparam logic [2:0] ERRI_NVM       = 3'h5;
	localparam logic [2:0] ERRI_OVER      = 3'h6;
	localparam logic [2:0] ERRI_UNDER     = 3'h7;
	localparam logic [7:0] ERR_BASE_NEW   = 8'h9D;
	localparam logic [7:0] ERR_BASE_OLD   = 8'h00;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] freq;
		logic [7:0]  temp;
		logic        nvm_fail;
	} meas_t;

	typedef struct packed {
		logic [15:0] fill_count;
		logic [7:0]  temp_or_err;
		logic [15:0] freq;
		logic        strobe;
		logic        err_active;
	} result_t;

endpackage

// ### design/fuel_level_pipeline.sv
`timescale 1ns/100ps
`default_nettype none
module fuel_level_pipeline (
	input  wire logic           clk,
	input  wire logic           reset,
	input  wire fuel_pkg::apb_req_t apb,
	input  wire fuel_pkg::meas_t    meas,
	output var  fuel_pkg::apb_rsp_t apb_rsp,
	output var  fuel_pkg::result_t  result,
	output logic [2:0]          baud_sel
);
	import fuel_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE, ST_AVG, ST_COMP, ST_LVL, ST_VOL, ST_FILL, ST_OUT
	} state_t;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	////////////////////////////////////////////////////////////////////
	// configuration and state storage
	logic               exp_smoothing_mode, comp_en_r, poly_r, legacy_r;
	logic [1:0]         box_log_r;
	logic [7:0]         interval_r, alpha_r;
	logic [15:0]        cal_empty_r, cal_full_r, gain_r, slope_r;
	logic signed [15:0] pa_r, pb_r, pc_r, pd_r;
	logic [15:0]        tank_r, fill_count_ceiling;
	logic [15:0]        tbl_lvl_r [TBL_N];
	logic [15:0]        tbl_vol_r [TBL_N];
	logic [15:0]        hist_r [TBL_N];
	logic [2:0]         wr_ptr_r;
	state_t             state_r;
	logic [15:0]        f_inst_r, fcomp_r, vol_r;
	logic signed [7:0]  temp_r;
	logic [23:0]        avg_r;
	logic [9:0]         lvl_r, fill_r;
	logic [7:0]         code_r;
	logic               err_r, primed_r;
	logic [9:0]         lvl_out_r, fill_out_r;
	logic [15:0]        vol_out_r, favg_out_r;

	logic wr_en;
	assign wr_en = apb.psel & apb.penable & apb_rsp.pready & apb.pwrite;

	// smoothing coefficient for a clamped interval
	function automatic logic [7:0] alpha_of(input logic [7:0] t);
		return 8'(ALPHA_Q8 / {8'h00, t});
	endfunction

	// error classification of one instantaneous sample
	function automatic logic [2:0] err_index(input logic [15:0] f,
			input logic nvm, input logic [15:0] ce, input logic [15:0] cf);
		logic [15:0] hi, lo;
		hi = (ce > cf) ? ce : cf;
		lo = (ce > cf) ? cf : ce;
		if (nvm) return ERRI_NVM;
		if (f == 16'h0000) return ERRI_ZERO_FREQ;
		if (ce == 16'h0000 && cf == 16'h0000) return ERRI_UNCAL_ALL;
		if (cf == 16'h0000) return ERRI_UNCAL_TOP;
		if (ce == cf) return ERRI_SAME_CAL;
		if ({4'h0, f} * 20'd10 > {4'h0, hi} * 20'd11) return ERRI_OVER;
		if ({4'h0, f} * 20'd10 < {4'h0, lo} * 20'd9) return ERRI_UNDER;
		return ERRI_NONE;
	endfunction

	////////////////////////////////////////////////////////////////////
	// software configuration writes
	always_ff @(posedge clk) begin
		if (reset) begin
			exp_smoothing_mode <= 1'b0;
			comp_en_r          <= 1'b0;
			poly_r             <= 1'b0;
			legacy_r           <= 1'b0;
			baud_sel           <= BAUD_19200;
			box_log_r          <= BOX_LOG_RST;
			interval_r         <= INTERVAL_RST;
			alpha_r            <= alpha_of(INTERVAL_RST);
			cal_empty_r        <= 16'h0000;
			cal_full_r         <= 16'h0000;
			gain_r             <= UNITY_Q8;
			slope_r            <= UNITY_Q8;
			pa_r               <= 16'sh0000;
			pb_r               <= 16'sh0000;
			pc_r               <= 16'sh0000;
			pd_r               <= 16'sh0000;
			tank_r             <= 16'h0000;
			fill_count_ceiling <= CEILING_RST;
		end else if (wr_en) begin
			case (apb.paddr)
				REG_CTRL: begin
					exp_smoothing_mode <= apb.pwdata[CTRL_EXP];
					comp_en_r          <= apb.pwdata[CTRL_COMP];
					poly_r             <= apb.pwdata[CTRL_POLY];
					legacy_r           <= apb.pwdata[CTRL_LEGACY];
					box_log_r          <= apb.pwdata[CTRL_BOX+:2];
					// unknown rate codes keep the old rate
					if (apb.pwdata[CTRL_BAUD+:3] <= BAUD_115200) begin
						baud_sel <= apb.pwdata[CTRL_BAUD+:3];
					end
				end
				REG_INTERVAL: begin
					if (apb.pwdata[7:0] < INTERVAL_MIN) begin
						interval_r <= INTERVAL_MIN;
						alpha_r    <= alpha_of(INTERVAL_MIN);
					end else begin
						interval_r <= apb.pwdata[7:0];
						alpha_r    <= alpha_of(apb.pwdata[7:0]);
					end
				end
				REG_CAL: begin
					cal_empty_r <= apb.pwdata[15:0];
					cal_full_r  <= apb.pwdata[31:16];
				end
				REG_COMP: begin
					gain_r  <= apb.pwdata[15:0];
					slope_r <= apb.pwdata[31:16];
				end
				REG_POLY_AB: begin
					pa_r <= apb.pwdata[15:0];
					pb_r <= apb.pwdata[31:16];
				end
				REG_POLY_CD: begin
					pc_r <= apb.pwdata[15:0];
					pd_r <= apb.pwdata[31:16];
				end
				REG_TANK: begin
					tank_r             <= apb.pwdata[15:0];
					fill_count_ceiling <= apb.pwdata[31:16];
				end
				default: ;
			endcase
		end
	end

	AST_INTERVAL_MIN: assert property (interval_r >= INTERVAL_MIN)
		else $error("interval below minimum");

	// level to volume table, one word per point
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < TBL_N; i++) begin
				tbl_lvl_r[i] <= 16'h0000;
				tbl_vol_r[i] <= 16'h0000;
			end
		end else if (wr_en && apb.paddr[7:5] == REG_TBL[7:5]) begin
			tbl_lvl_r[apb.paddr[4:2]] <= apb.pwdata[15:0];
			tbl_vol_r[apb.paddr[4:2]] <= apb.pwdata[31:16];
		end
	end

	////////////////////////////////////////////////////////////////////
	// apb response, ready in the access phase with no wait state
	logic [31:0] rd_data;
	logic        rd_err;
	always_comb begin
		rd_err  = 1'b0;
		rd_data = 32'h0000_0000;
		case (apb.paddr)
			REG_CTRL: rd_data = {22'h0, box_log_r, 1'b0, baud_sel, legacy_r,
				poly_r, comp_en_r, exp_smoothing_mode};
			REG_INTERVAL: rd_data = {16'h0, alpha_r, interval_r};
			REG_CAL:      rd_data = {cal_full_r, cal_empty_r};
			REG_COMP:     rd_data = {slope_r, gain_r};
			REG_POLY_AB:  rd_data = {pb_r, pa_r};
			REG_POLY_CD:  rd_data = {pd_r, pc_r};
			REG_TANK:     rd_data = {fill_count_ceiling, tank_r};
			REG_OUT:      rd_data = {8'h0, result.temp_or_err, result.fill_count};
			REG_FREQ:     rd_data = {favg_out_r, result.freq};
			REG_CALC:     rd_data = {vol_out_r, 6'h0, lvl_out_r};
			REG_STAT:     rd_data = {7'h0, result.err_active, code_r, 6'h0, fill_out_r};
			default: begin
				if (apb.paddr[7:5] == REG_TBL[7:5] && apb.paddr[1:0] == 2'h0) begin
					rd_data = {tbl_vol_r[apb.paddr[4:2]], tbl_lvl_r[apb.paddr[4:2]]};
				end else begin
					rd_err = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			apb_rsp <= '0;
		end else begin
			apb_rsp.pready  <= apb.psel & ~apb.penable & ~apb_rsp.pready;
			apb_rsp.prdata  <= (apb.pwrite || rd_err) ? 32'h0 : rd_data;
			apb_rsp.pslverr <= apb.psel & ~apb.penable & rd_err;
		end
	end

	AST_APB_READY: assert property (apb.psel && !apb.penable && !apb_rsp.pready
		|=> apb_rsp.pready ##1 !apb_rsp.pready)
		else $error("apb ready not one cycle after setup");

	////////////////////////////////////////////////////////////////////
	// sequencing, one pass per completed measurement
	logic [2:0] eidx;
	logic       take;
	assign eidx = err_index(meas.freq, meas.nvm_fail, cal_empty_r, cal_full_r);
	assign take = (state_r == ST_IDLE) && meas.valid;

	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= ST_IDLE;
		end else begin
			unique case (state_r)
				ST_IDLE: if (meas.valid) begin
					state_r <= (eidx != ERRI_NONE) ? ST_OUT : ST_AVG;
				end
				ST_AVG:  state_r <= ST_COMP;
				ST_COMP: state_r <= ST_LVL;
				ST_LVL:  state_r <= ST_VOL;
				ST_VOL:  state_r <= ST_FILL;
				ST_FILL: state_r <= ST_OUT;
				ST_OUT:  state_r <= ST_IDLE;
			endcase
		end
	end

	sequence s_take;
		take;
	endsequence
	sequence s_publish;
		result.strobe;
	endsequence
	AST_CHAIN_LEN: assert property (s_take |-> ##[2:7] s_publish)
		else $error("measurement not published in time");

	// sample capture and diagnostic code
	always_ff @(posedge clk) begin
		if (reset) begin
			f_inst_r <= 16'h0000;
			temp_r   <= 8'sh00;
			code_r   <= 8'h00;
			err_r    <= 1'b0;
		end else if (take) begin
			f_inst_r <= meas.freq;
			temp_r   <= meas.temp;
			if (eidx != ERRI_NONE) begin
				err_r  <= 1'b1;
				code_r <= (legacy_r ? ERR_BASE_OLD : ERR_BASE_NEW)
					- {5'h00, eidx};
			end else begin
				err_r <= 1'b0;
			end
		end
	end

	AST_ZERO_CODE: assert property (take && !meas.nvm_fail
		&& meas.freq == 16'h0000 && !legacy_r
		|=> err_r && code_r == ERR_BASE_NEW - {5'h00, ERRI_ZERO_FREQ})
		else $error("zero frequency code wrong");
	AST_ERR_CLEAR: assert property (take && eidx == ERRI_NONE |=> !err_r)
		else $error("error not cleared by valid sample");

	////////////////////////////////////////////////////////////////////
	// sample history, primed with the first sample
	always_ff @(posedge clk) begin
		if (reset) begin
			wr_ptr_r <= 3'h0;
			for (int i = 0; i < TBL_N; i++) begin
				hist_r[i] <= 16'h0000;
			end
		end else if (take && eidx == ERRI_NONE) begin
			wr_ptr_r <= wr_ptr_r + 3'h1;
			if (!primed_r) begin
				for (int i = 0; i < TBL_N; i++) begin
					hist_r[i] <= meas.freq;
				end
			end else begin
				hist_r[wr_ptr_r] <= meas.freq;
			end
		end
	end

	// averaging, boxcar mean or exponential step
	logic [18:0]        box_sum;
	logic signed [24:0] diff;
	logic signed [33:0] step;
	always_comb begin
		box_sum = 19'h0;
		for (int k = 0; k < TBL_N; k++) begin
			if (k < (1 << box_log_r)) begin
				box_sum = box_sum + {3'h0, hist_r[3'(wr_ptr_r - 3'(k + 1))]};
			end
		end
		diff = $signed({1'b0, f_inst_r, 8'h00}) - $signed({1'b0, avg_r});
		step = (34'(diff) * $signed({1'b0, alpha_r})) >>> 8;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			avg_r    <= 24'h0;
			primed_r <= 1'b0;
		end else if (state_r == ST_AVG) begin
			primed_r <= 1'b1;
			if (!primed_r) begin
				avg_r <= {f_inst_r, 8'h00};
			end else if (exp_smoothing_mode) begin
				avg_r <= 24'(avg_r + 24'(step));
			end else begin
				avg_r <= {16'(box_sum >> box_log_r), 8'h00};
			end
		end
	end

	AST_INIT_LOAD: assert property (state_r == ST_AVG && !primed_r
		|=> avg_r == {f_inst_r, 8'h00})
		else $error("first sample did not load the average");
	AST_ERR_HOLDS_AVG: assert property (take && eidx != ERRI_NONE
		|=> $stable(avg_r) [*2])
		else $error("average changed on bad sample");

	////////////////////////////////////////////////////////////////////
	// temperature compensation, immersion, volume and fill
	logic signed [17:0] slope_d, gain;
	logic signed [25:0] tprod;
	logic signed [34:0] fprod;
	logic [15:0]        fc;
	logic signed [16:0] dn, dd;
	logic signed [27:0] lq;
	always_comb begin
		slope_d = $signed({2'b00, slope_r}) - $signed({2'b00, UNITY_Q8});
		tprod   = slope_d * temp_r;
		gain    = $signed({2'b00, gain_r}) + 18'(tprod >>> 8);
		fprod   = $signed({1'b0, avg_r[23:8]}) * gain;
		if (!comp_en_r) begin
			fc = avg_r[23:8];
		end else if (fprod[34]) begin
			fc = 16'h0000;
		end else if (|fprod[33:24]) begin
			fc = 16'hFFFF;
		end else begin
			fc = fprod[23:8];
		end
		dn = $signed({1'b0, fcomp_r}) - $signed({1'b0, cal_empty_r});
		dd = $signed({1'b0, cal_full_r}) - $signed({1'b0, cal_empty_r});
		lq = (28'(dn) * 28'(LVL_SCALE)) / ((dd == 17'sh0) ? 28'sh1 : 28'(dd));
	end

	// cubic and table lookup
	logic [19:0]        l2, l3;
	logic signed [31:0] pv;
	logic [2:0]         seg;
	logic signed [33:0] tv;
	logic [15:0]        vol_nxt;
	always_comb begin
		l2  = ({10'h0, lvl_r} * {10'h0, lvl_r}) >> 10;
		l3  = (l2 * {10'h0, lvl_r}) >> 10;
		pv  = (pa_r * $signed({1'b0, l3[10:0]})
			+ pb_r * $signed({1'b0, l2[10:0]})
			+ pc_r * $signed({1'b0, lvl_r})) >>> 10;
		pv  = pv + 32'(pd_r);
		seg = 3'h0;
		for (int i = 0; i < TBL_N - 1; i++) begin
			if ({6'h0, lvl_r} >= tbl_lvl_r[i]) begin
				seg = 3'(i);
			end
		end
		if ({6'h0, lvl_r} <= tbl_lvl_r[seg]) begin
			tv = 34'(tbl_vol_r[seg]);
		end else if ({6'h0, lvl_r} >= tbl_lvl_r[seg + 3'h1]) begin
			tv = 34'(tbl_vol_r[seg + 3'h1]);
		end else begin
			// kept signed so a falling volume segment interpolates too
			tv = $signed(34'(tbl_vol_r[seg]))
				+ ($signed(34'({6'h0, lvl_r} - tbl_lvl_r[seg]))
				* ($signed({18'h0, tbl_vol_r[seg + 3'h1]})
				- $signed({18'h0, tbl_vol_r[seg]})))
				/ $signed(34'(tbl_lvl_r[seg + 3'h1] - tbl_lvl_r[seg]));
		end
		if (poly_r) begin
			vol_nxt = (pv < 0) ? 16'h0 : (|pv[31:16]) ? 16'hFFFF : pv[15:0];
		end else begin
			vol_nxt = (tv < 0) ? 16'h0 : (|tv[33:16]) ? 16'hFFFF : tv[15:0];
		end
	end

	logic [25:0] fq;
	logic [25:0] cnt;
	always_comb begin
		fq  = (tank_r == 16'h0) ? 26'h0
			: ({10'h0, vol_r} * 26'(LVL_SCALE)) / {10'h0, tank_r};
		cnt = ({16'h0, fill_r} * {10'h0, fill_count_ceiling})
			/ 26'(LVL_SCALE);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			fcomp_r <= 16'h0;
			lvl_r   <= 10'h0;
			vol_r   <= 16'h0;
			fill_r  <= 10'h0;
		end else begin
			if (state_r == ST_COMP) fcomp_r <= fc;
			if (state_r == ST_LVL) begin
				lvl_r <= (lq < 0) ? 10'h0 : (lq > 28'(LVL_SCALE))
					? 10'(LVL_SCALE) : lq[9:0];
			end
			if (state_r == ST_VOL) vol_r <= vol_nxt;
			if (state_r == ST_FILL) begin
				fill_r <= (fq > 26'(LVL_SCALE)) ? 10'(LVL_SCALE) : fq[9:0];
			end
		end
	end

	AST_COMP_BYPASS: assert property (state_r == ST_COMP && !comp_en_r
		|=> fcomp_r == $past(avg_r[23:8]))
		else $error("compensation altered frequency while off");

	////////////////////////////////////////////////////////////////////
	// published outputs; an error pass keeps fill count, level, volume and fill from the last good pass
	always_ff @(posedge clk) begin
		if (reset) begin
			result     <= '0;
			lvl_out_r  <= 10'h0;
			vol_out_r  <= 16'h0;
			fill_out_r <= 10'h0;
			favg_out_r <= 16'h0;
		end else begin
			result.strobe <= (state_r == ST_OUT);
			if (state_r == ST_OUT) begin
				result.freq       <= f_inst_r;
				result.err_active <= err_r;
				favg_out_r        <= avg_r[23:8];
				if (err_r) begin
					result.temp_or_err <= code_r;
				end else begin
					result.temp_or_err <= temp_r;
					result.fill_count  <= cnt[15:0];
					lvl_out_r          <= lvl_r;
					vol_out_r          <= vol_r;
					fill_out_r         <= fill_r;
				end
			end
		end
	end

	AST_TEMP_FIELD: assert property (state_r == ST_OUT && !err_r
		|=> result.strobe && result.temp_or_err == $past(temp_r))
		else $error("temperature field wrong");
	AST_FREQ_FIELD: assert property (state_r == ST_OUT
		|=> result.freq == $past(f_inst_r))
		else $error("frequency field not instantaneous");

endmodule // fuel_level_pipeline
`default_nettype wire

// ### tb/meas_source.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// oscillator front end: one period measurement, then waits for publication
module meas_source (
	input  wire logic              clk,
	input  wire fuel_pkg::result_t res,
	output var  fuel_pkg::meas_t   meas
);
	import fuel_pkg::*;

	initial meas = '0;

	// valid pulses one cycle; stale fields are scrambled once it drops
	task automatic send(input logic [15:0] f, input logic [7:0] t,
			input logic nf, output logic ok);
		int n;
		@(posedge clk);
		meas <= '{1'b1, f, t, nf};
		@(posedge clk);
		meas <= '{1'b0, ~f, ~t, ~nf};
		ok = 1'b0;
		for (n = 0; n < 20 && !ok; n++) begin
			@(posedge clk);
			ok = (res.strobe === 1'b1);
		end
	endtask
endmodule // meas_source
`default_nettype wire

// ### tb/tb_fuel_level_measurement_pipeline.sv
`timescale 1ns/100ps
`default_nettype none
module tb_fuel_level_measurement_pipeline;
	import fuel_pkg::*;
	localparam logic [31:0] CT = 32'h0000_0220;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	apb_req_t    apb = '0;
	apb_rsp_t    apb_rsp;
	meas_t       meas;
	result_t     result;
	logic [2:0]  baud_sel;
	int          fail_count = 0;
	int          checks = 0;
	logic [31:0] rd;
	logic        err;
	logic        ok;

	always #5 clk = ~clk;

	fuel_level_pipeline dut (.clk(clk), .reset(reset), .apb(apb),
		.meas(meas), .apb_rsp(apb_rsp), .result(result), .baud_sel(baud_sel));
	meas_source src (.clk(clk), .res(result), .meas(meas));

	////////////////////////////////////////////////////////////////////////
	// comparison and verdict
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// apb master: setup, access held until pready, then release
	task automatic xfer(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge clk);
		apb <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		apb.penable <= 1'b1;
		// pready ends this wait; if it never rises, only the watchdog does
		do begin
			@(posedge clk);
		end while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb <= '0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rdr(input logic [7:0] a);
		xfer(1'b0, a, 32'h0);
	endtask

	task automatic do_reset(input int n);
		reset <= 1'b1;
		repeat (n) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
	endtask

	// fresh start: cal 1000..2000, tank 2000, ceiling 1000, bent table
	task automatic setup(input logic [31:0] ctrl);
		int i;
		do_reset(2);
		wr(REG_CAL, 32'h07D0_03E8);
		wr(REG_TANK, 32'h03E8_07D0);
		for (i = 0; i < TBL_N; i++)
			wr(REG_TBL + 8'(4 * i),
				i < 7 ? {16'(100 * i), 16'(100 * i)} : 32'h0640_03E8);
		wr(REG_CTRL, ctrl);
	endtask

	task automatic sample(input logic [15:0] f, input logic nf);
		src.send(f, 8'h19, nf, ok);
		check(32'(ok), 32'h1);
	endtask

	////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		check(32'(baud_sel), 32'h2);
		rdr(REG_CTRL);
		check(rd, CT);
		rdr(REG_INTERVAL);
		check(32'(rd[15:0]), 32'h590A);
		rdr(REG_COMP);
		check(rd, 32'h0100_0100);
		rdr(REG_TANK);
		check(32'(rd[31:16]), 32'h03FF);
		rdr(8'h30);
		check({rd[30:0], err}, 32'h1);
	endtask

	// rate register settles one edge after the write lands
	task automatic t_cfg();
		int i;
		for (i = 0; i < 6; i++) begin
			wr(REG_CTRL, CT & ~32'h70 | 32'(i << 4));
			@(posedge clk);
			check(32'(baud_sel), 32'(i));
		end
		wr(REG_CTRL, CT | 32'h70);
		@(posedge clk);
		check(32'(baud_sel), 32'h5);
		wr(REG_INTERVAL, 32'h3);
		rdr(REG_INTERVAL);
		check(32'(rd[15:0]), 32'hB305);
		wr(REG_INTERVAL, 32'h14);
		rdr(REG_INTERVAL);
		check(32'(rd[15:0]), 32'h2C14);
	endtask

	task automatic t_chain();
		setup(CT);
		sample(16'd1800, 1'b0);
		check(32'(result.fill_count), 32'd550);
		check(32'(result.temp_or_err), 32'h19);
		check(32'(result.freq), 32'd1800);
		rdr(REG_FREQ);
		check(rd, {16'd1800, 16'd1800});
		rdr(REG_CALC);
		check(rd, {16'd1100, 16'd800});
		rdr(REG_STAT);
		check(32'(rd[9:0]), 32'd550);
		sample(16'd1000, 1'b0);
		rdr(REG_FREQ);
		check(rd, {16'd1600, 16'd1000});
		rdr(REG_OUT);
		check(32'(rd[23:0]), 32'h19_012C);
		sample(16'd0, 1'b0);
		check({result.temp_or_err, 7'h0, result.err_active}, 32'h9A01);
		check(32'(result.fill_count), 32'h12C);
		rdr(REG_FREQ);
		check(rd, {16'd1600, 16'd0});
		rdr(REG_STAT);
		check(32'(rd[24:16]), 32'h19A);
		sample(16'd1600, 1'b0);
		check(32'(result.err_active), 32'h0);
		rdr(REG_FREQ);
		check(32'(rd[31:16]), 32'd1550);
	endtask

	// every diagnostic code, both code sets, plus range edges that pass
	task automatic t_codes();
		logic [31:0] cal[9] = '{32'h07D0_03E8, 32'h07D0_03E8, 32'h0,
			32'h0000_03E8, 32'h03E8_03E8, 32'h07D0_03E8, 32'h07D0_03E8,
			32'h07D0_03E8, 32'h07D0_03E8};
		logic [15:0] fq[9] = '{1000, 0, 1000, 1000, 1000, 2201, 899, 2200, 900};
		logic [7:0] ix[9] = '{5, 3, 1, 2, 4, 6, 7, 0, 0};
		logic [7:0] ex;
		int i;
		int lg;
		for (lg = 0; lg < 2; lg++) begin
			for (i = 0; i < 9; i++) begin
				setup(CT | 32'(lg << 3));
				wr(REG_CAL, cal[i]);
				sample(fq[i], i == 0);
				// code byte wraps at eight bits, as sent on the link
				ex = (lg ? 8'h00 : 8'h9D) - ix[i];
				check(32'(result.err_active), 32'(ix[i] != 0));
				check(32'(result.temp_or_err),
					ix[i] == 0 ? 32'h19 : 32'(ex));
			end
		end
	endtask

	task automatic t_math();
		setup(CT | 32'h4);
		wr(REG_POLY_AB, 32'h0400_0400);
		wr(REG_POLY_CD, 32'h0064_0400);
		sample(16'd1800, 1'b0);
		rdr(REG_CALC);
		check(32'(rd[31:16]), 32'd2013);
		check(32'(result.fill_count), 32'd1000);
		setup(CT | 32'h2);
		wr(REG_COMP, 32'h0100_0180);
		sample(16'd1200, 1'b0);
		rdr(REG_CALC);
		check(32'(rd[9:0]), 32'd800);
		// slope term: 1200 * (256 + 25) / 256 gives 1317
		setup(CT | 32'h2);
		wr(REG_COMP, 32'h0200_0100);
		sample(16'd1200, 1'b0);
		rdr(REG_CALC);
		check(32'(rd[9:0]), 32'd317);
		setup(CT);
		wr(REG_COMP, 32'h0100_0180);
		sample(16'd1200, 1'b0);
		rdr(REG_CALC);
		check(32'(rd[9:0]), 32'd200);
		setup(CT | 32'h1);
		sample(16'd1000, 1'b0);
		rdr(REG_FREQ);
		check(32'(rd[31:16]), 32'd1000);
		sample(16'd2000, 1'b0);
		rdr(REG_FREQ);
		check(32'(rd[31:16]), 32'd1347);
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence and watchdog
	initial begin
		do_reset(20);
		t_reset();
		t_cfg();
		t_chain();
		t_codes();
		t_math();
		tally_and_finish();
	end

	initial begin
		#500000;
		fail_count++;
		tally_and_finish();
	end
endmodule // tb_fuel_level_measurement_pipeline
`default_nettype wire
